// ==== testbench/lsa_sysref_src.sv ====
`timescale 1ns/10ps

// SYSREF source; the line stays low between pulses
module lsa_sysref_src #(
   parameter int HIGH_CYC = 3
) (
   input wire logic clk,
   input wire logic fire,
   output logic sysref_in
);
   logic [3:0] cnt_q = 4'h0;
   always_ff @(posedge clk) begin
      if (fire) begin
         cnt_q <= 4'(HIGH_CYC);
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end
   assign sysref_in = (cnt_q != 4'h0);
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
`include "lsa_regs.svh"

module tb;
   localparam logic [11:0] CT = `LSA_ADDR_CTRL;
   localparam logic [11:0] ST = `LSA_ADDR_STAT;
   localparam logic [11:0] PE = `LSA_ADDR_PERR;
   localparam logic [11:0] PF = `LSA_ADDR_PFLAGS;
   logic clk;
   logic rst_b;
   logic fire;
   logic sysref_in;
   logic lmfc_realign;
   logic [7:0] reg_rdata;
   lsa_pkg::lsa_reg_req_type req;
   int num_errors = 0;
   int tests_run = 0;
   int n_realign = 0;
   time t_last = 0;

   lsa_ctrl i_dut (.clk(clk), .rst_b(rst_b), .req(req), .sysref_in(sysref_in),
      .reg_rdata(reg_rdata), .lmfc_realign(lmfc_realign));
   lsa_sysref_src i_src (.clk(clk), .fire(fire), .sysref_in(sysref_in));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      if (lmfc_realign === 1'b1) n_realign <= n_realign + 1;
   end

   task automatic test_done();
      if (num_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk) #1 req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(posedge clk) #1 req.wr = 1'b0;
   endtask

   // Read, then compare the masked byte
   task automatic rdc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk) #1 req.rd = 1'b1;
      req.addr = a;
      @(posedge clk) #1 req.rd = 1'b0;
      @(posedge clk) #1 chk(reg_rdata & m, e);
   endtask

   // Gap counted fire to fire keeps the phase known after the first event
   task automatic pulse(input int gap, input int adj);
      int n0;
      @(posedge clk);
      while (($time - t_last) < gap * 4 - 1) @(posedge clk);
      #1 fire = 1'b1;
      t_last = $time;
      n0 = n_realign;
      @(posedge clk) #1 fire = 1'b0;
      repeat (10) @(posedge clk);
      if (adj < 2) chk(8'(n_realign - n0), 8'(adj));
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      test_done();
   end

   initial begin
      req = '0;
      fire = 1'b0;
      rst_b = 1'b0;
      repeat (12) @(posedge clk);
      #1 rst_b = 1'b1;
      rdc(CT, 8'hff, 8'h00);
      rdc(ST, 8'hff, 8'h00);
      rdc(12'h03f, 8'hff, 8'h00);
      wr(CT, 8'h82);
      pulse(40, 2);
      wr(`LSA_ADDR_TOL, 8'h03);
      pulse(69, 1);
      rdc(PE, 8'hff, 8'h05);
      rdc(PF, 8'hff, 8'h40);
      rdc(ST, 8'hfe, 8'h0e);
      pulse(59, 1);
      rdc(PE, 8'hff, 8'h0b);
      rdc(PF, 8'hff, 8'h80);
      pulse(67, 0);
      rdc(ST, 8'hfe, 8'h0c);
      wr(CT, 8'hb2);
      rdc(PE, 8'hff, 8'h00);
      rdc(PF, 8'hff, 8'h00);
      rdc(ST, 8'hff, 8'h08);
      pulse(65, 1);
      rdc(PF, 8'hff, 8'h40);
      wr(CT, 8'h88);
      pulse(70, 0);
      rdc(ST, 8'h86, 8'h06);
      rdc(PE, 8'hff, 8'h04);
      wr(CT, 8'ha1);
      rdc(ST, 8'h05, 8'h00);
      pulse(64, 0);
      rdc(ST, 8'h01, 8'h00);
      wr(CT, 8'hc1);
      rdc(ST, 8'h80, 8'h80);
      pulse(64, 1);
      rdc(ST, 8'h85, 8'h05);
      pulse(69, 0);
      wr(CT, 8'hc9);
      pulse(69, 1);
      rdc(PE, 8'hff, 8'h07);
      pulse(69, 0);
      rdc(ST, 8'h82, 8'h02);
      wr(CT, 8'h09);
      pulse(69, 0);
      rdc(ST, 8'h8a, 8'h00);
      wr(CT, 8'hc1);
      rdc(ST, 8'h80, 8'h80);
      test_done();
   end
endmodule

// ==== verilog/lsa_ctrl.sv ====
`timescale 1ns/10ps
`include "lsa_regs.svh"

// Summary of operation
// (RULE_01) Last error below window sets under flag
// (RULE_02) Last error above window sets over flag
// (RULE_03) Control bit 7 enables logic, reset off
// (RULE_04) Writing control bit 6 arms one-shot; code arms only when the same write sets bit 7 and a one-shot mode
// (RULE_05) Rising bit 5 clears rotated and tripped
// (RULE_06) Rising bit 4 clears previous error, flags
// (RULE_07) Mode field picks one-shot, continuous, monitor
// (RULE_08) Monitor mode measures, never adjusts; code adjusts in monitor mode if a one-shot arm is still pending in WAIT
// (RULE_09) Status bit 7 shows machine busy
// (RULE_10) Status bit 3 shows aligned within window
// (RULE_11) Status bit 2 sticky rotated flag
// (RULE_12) Status bit 1 shows error outside window
// (RULE_13) Status bit 0 sticky SYSREF after arming
// (RULE_14) Errors within plus/minus tolerance cause no adjust
// (RULE_15) Previous error kept as 4-bit signed
// (RULE_16) Adjust copies error, zeroes current error
// (RULE_17) Software enables, sets mode, arms, polls busy
module lsa_ctrl #(
   parameter int unsigned LMFC_PERIOD = `LSA_LMFC_PERIOD
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire lsa_pkg::lsa_reg_req_type req,
   input wire logic sysref_in,
   output logic [7:0] reg_rdata,
   output logic lmfc_realign
);

   localparam int unsigned PW = $clog2(LMFC_PERIOD);

   // Signed phase error, saturated to the 4-bit stored range
   function automatic logic signed [3:0] phase_err(input logic [PW-1:0] ph);
      logic signed [PW+1:0] e;
      e = signed'({2'b00, ph});
      if (ph >= PW'(LMFC_PERIOD / 2)) begin
         e = e - signed'((PW+2)'(LMFC_PERIOD));
      end
      if (e > signed'((PW+2)'(4'sh7))) begin
         return 4'sh7;
      end else if (e < signed'((PW+2)'(4'sh8))) begin
         return 4'sh8;
      end else begin
         return signed'(e[3:0]);
      end
   endfunction

   // Returns {below, above} for a tolerance of plus/minus tol
   function automatic logic [1:0] window_side(input logic signed [3:0] err, input logic [1:0] tol);
      logic signed [3:0] t;
      t = signed'({2'b00, tol});
      return {err < -t, err > t};
   endfunction

   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [1:0] tol_q;
   logic [PW-1:0] ph_q;
   logic [PW-1:0] ph_d;
   logic signed [3:0] perr_q;
   logic under_q;
   logic over_q;
   logic lock_q;
   logic rot_q;
   logic wlim_q;
   logic trip_q;
   logic sr_m_q;
   logic sr_s_q;
   logic sr_p_q;
   logic realign_q;
   logic [7:0] rdata_q;
   lsa_pkg::lsa_state_type state_q;
   lsa_pkg::lsa_state_type state_d;

   wire ctrl_wr = req.wr && (req.addr == `LSA_ADDR_CTRL);
   wire tol_wr = req.wr && (req.addr == `LSA_ADDR_TOL);
   wire enable = ctrl_q[`LSA_CTRL_ON];
   wire [3:0] mode = ctrl_q[3:0];
   wire [3:0] wr_mode = req.wdata[3:0];
   wire clr_sticky = ctrl_wr && req.wdata[`LSA_CTRL_CLRSTKY] && !ctrl_q[`LSA_CTRL_CLRSTKY];
   wire clr_prev = ctrl_wr && req.wdata[`LSA_CTRL_CLRPREV] && !ctrl_q[`LSA_CTRL_CLRPREV];
   wire wr_oneshot = (wr_mode == lsa_pkg::LSA_MODE_ONE_SHOT) || (wr_mode == lsa_pkg::LSA_MODE_OS_MON);
   wire arm_now = ctrl_wr && req.wdata[`LSA_CTRL_ARM] && req.wdata[`LSA_CTRL_ON] && wr_oneshot;
   wire mode_cont = (mode == lsa_pkg::LSA_MODE_CONT);
   wire mode_mon = (mode == lsa_pkg::LSA_MODE_MON);
   wire mode_osmon = (mode == lsa_pkg::LSA_MODE_OS_MON);
   wire busy = (state_q != lsa_pkg::LSA_ST_IDLE);
   wire sr_evt = sr_s_q && !sr_p_q && enable;
   wire signed [3:0] cur_err = phase_err(ph_q);
   wire [1:0] side = window_side(cur_err, tol_q);
   wire out_win = |side;
   // Arming only in the one-shot modes, so monitor reaches an adjust only on a one-shot arm still pending in WAIT
   wire acting = sr_evt && ((state_q == lsa_pkg::LSA_ST_WAIT) || mode_cont); // [RULE_07]
   wire measuring = acting || (sr_evt && (mode_mon || mode_osmon)); // [RULE_08]
   wire adjust = acting && out_win; // [RULE_14]
   wire [7:0] status_w = {busy, 3'h0, lock_q, rot_q, wlim_q, trip_q}; // [RULE_09]
   wire [7:0] pflags_w = {under_q, over_q, 6'h00};
   wire [7:0] perr_w = {4'h0, perr_q};
   wire [7:0] tol_w = {6'h00, tol_q};
   wire [7:0] rd_mux = (req.addr == `LSA_ADDR_CTRL) ? ctrl_q :
                       (req.addr == `LSA_ADDR_STAT) ? status_w :
                       (req.addr == `LSA_ADDR_PERR) ? perr_w :
                       (req.addr == `LSA_ADDR_PFLAGS) ? pflags_w :
                       (req.addr == `LSA_ADDR_TOL) ? tol_w : 8'h00;

   assign ctrl_d = ctrl_wr ? req.wdata : ctrl_q; // [RULE_03]
   // Rotation restarts the LMFC so this SYSREF sample lands on phase zero
   assign ph_d = adjust ? PW'(1) :
                 (ph_q == PW'(LMFC_PERIOD - 1)) ? '0 : PW'(ph_q + PW'(1)); // [RULE_16]
   assign reg_rdata = rdata_q;
   assign lmfc_realign = realign_q;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         lsa_pkg::LSA_ST_IDLE: begin
            if (arm_now) begin
               state_d = lsa_pkg::LSA_ST_WAIT; // [RULE_04]
            end else if (adjust) begin
               state_d = lsa_pkg::LSA_ST_ADJ;
            end
         end
         lsa_pkg::LSA_ST_WAIT: begin
            if (adjust) begin
               state_d = lsa_pkg::LSA_ST_ADJ;
            end else if (sr_evt) begin
               state_d = lsa_pkg::LSA_ST_IDLE;
            end
         end
         lsa_pkg::LSA_ST_ADJ: begin
            state_d = lsa_pkg::LSA_ST_IDLE;
         end
         default: begin
            state_d = lsa_pkg::LSA_ST_IDLE;
         end
      endcase
      // An enabling write may arm in the same cycle, so it is not overridden
      if (!enable && !arm_now) begin
         state_d = lsa_pkg::LSA_ST_IDLE; // [RULE_03]
      end
   end

   // Two-flop synchroniser, edge taken from the second stage only
   always_ff @(posedge clk) begin
      sr_m_q <= rst_b && sysref_in;
      sr_s_q <= rst_b && sr_m_q;
      sr_p_q <= rst_b && sr_s_q;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl_q <= `LSA_CTRL_RST;
         tol_q <= `LSA_TOL_RST;
         state_q <= lsa_pkg::LSA_ST_IDLE;
         ph_q <= '0;
         realign_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
         tol_q <= tol_wr ? req.wdata[1:0] : tol_q;
         state_q <= state_d;
         ph_q <= ph_d;
         realign_q <= adjust;
         rdata_q <= req.rd ? rd_mux : rdata_q;
      end
   end

   // A new adjust wins over a clear arriving in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         perr_q <= `LSA_PERR_RST;
         under_q <= 1'b0;
         over_q <= 1'b0;
      end else if (adjust) begin
         perr_q <= cur_err; // [RULE_15] [RULE_16]
         under_q <= side[1]; // [RULE_01]
         over_q <= side[0]; // [RULE_02]
      end else if (clr_prev) begin
         perr_q <= `LSA_PERR_RST; // [RULE_06]
         under_q <= 1'b0;
         over_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rot_q <= 1'b0;
         trip_q <= 1'b0;
         lock_q <= 1'b0;
         wlim_q <= 1'b0;
      end else begin
         rot_q <= adjust || (rot_q && !clr_sticky); // [RULE_11] [RULE_05]
         trip_q <= (sr_evt && state_q == lsa_pkg::LSA_ST_WAIT) || (trip_q && !clr_sticky); // [RULE_13]
         if (!enable) begin
            lock_q <= 1'b0;
            wlim_q <= 1'b0;
         end else if (measuring) begin
            lock_q <= !out_win || adjust; // [RULE_10]
            wlim_q <= out_win; // [RULE_12]
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   chk_under_flag: assert property (adjust && side[1] |=> under_q && !over_q) // [RULE_01]
      else $error("under flag not set on low adjust");
   chk_over_flag: assert property (adjust && side[0] |=> over_q && !under_q) // [RULE_02]
      else $error("over flag not set on high adjust");
   chk_disable_idle: assert property (!enable && !arm_now |=> state_q == lsa_pkg::LSA_ST_IDLE && !lmfc_realign) // [RULE_03]
      else $error("machine active while disabled");
   chk_arm_waits: assert property (arm_now && !busy |=> state_q == lsa_pkg::LSA_ST_WAIT) // [RULE_04]
      else $error("arm did not start one-shot");
   chk_sticky_clear: assert property (clr_sticky && !adjust && !sr_evt |=> !rot_q && !trip_q) // [RULE_05]
      else $error("sticky flags survived clear");
   chk_prev_clear: assert property (clr_prev && !adjust |=> perr_q == 4'sh0 && !under_q && !over_q) // [RULE_06]
      else $error("previous error survived clear");
   chk_monitor_hold: assert property (mode_mon && !busy |-> !adjust ##1 !lmfc_realign) // [RULE_08]
      else $error("monitor mode adjusted the clock");
   chk_busy_read: assert property (req.rd && req.addr == `LSA_ADDR_STAT |=> reg_rdata[7] == $past(busy)) // [RULE_09]
      else $error("busy bit does not match machine");
   chk_rot_sticky: assert property (rot_q && !clr_sticky |=> rot_q) // [RULE_11]
      else $error("rotated flag dropped without clear");
   chk_trip_set: assert property (sr_evt && state_q == lsa_pkg::LSA_ST_WAIT |=> trip_q ##1 !busy) // [RULE_13]
      else $error("trip not set or one-shot not finished");
   chk_window_pass: assert property (measuring && !out_win |=> lock_q && !wlim_q && !lmfc_realign) // [RULE_14]
      else $error("in-window error handled wrongly");
   chk_prev_store: assert property (adjust |=> perr_q == $past(cur_err) && lmfc_realign ##1 !lmfc_realign) // [RULE_16]
      else $error("error not stored on adjust");

endmodule

// ==== verilog/lsa_pkg.sv ====
package lsa_pkg;

   typedef enum logic [3:0] {
      LSA_MODE_ONE_SHOT = 4'h1,
      LSA_MODE_CONT = 4'h2,
      LSA_MODE_MON = 4'h8,
      LSA_MODE_OS_MON = 4'h9
   } lsa_mode_type;

   typedef enum logic [1:0] {
      LSA_ST_IDLE = 2'b00,
      LSA_ST_WAIT = 2'b01,
      LSA_ST_ADJ = 2'b10
   } lsa_state_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [7:0] wdata;
   } lsa_reg_req_type;

endpackage

// ==== verilog/lsa_regs.svh ====
`ifndef LSA_REGS_SVH
`define LSA_REGS_SVH

// Register offsets
`define LSA_ADDR_TOL 12'h034
`define LSA_ADDR_PERR 12'h038
`define LSA_ADDR_PFLAGS 12'h039
`define LSA_ADDR_CTRL 12'h03a
`define LSA_ADDR_STAT 12'h03b

// align_control field positions
`define LSA_CTRL_ON 7
`define LSA_CTRL_ARM 6
`define LSA_CTRL_CLRSTKY 5
`define LSA_CTRL_CLRPREV 4

// Flag positions in the previous-error flag byte
`define LSA_PFLAG_UNDER 7
`define LSA_PFLAG_OVER 6

// Reset values
`define LSA_CTRL_RST 8'h00
`define LSA_TOL_RST 2'h0
`define LSA_PERR_RST 4'h0

// LMFC period in DAC clocks
`define LSA_LMFC_PERIOD 32

`endif
